// >>> rtl/gpio_group_six_seven_port.sv
// Overview of operation
// R1: Output bits keep written data, drive it to the pin, read it back.
// R2: Input bits read the pin level; writes to them are ignored.
// R3: Inversion bit 1 inverts data against pin, for inputs and outputs alike.
// R4: Any rising or falling pin edge sets that pin's event status bit.
// R5: Reading an event status register clears its implemented bits.
// R6: Group-six status bits 7..0 follow group-six pins 7..0.
// R7: Group seven implements bit 1 only; all other bits are reserved.
// R8: Group-seven direction 0 is output, 1 input; resets to 02h.
// R9: Control bit 1 turns the base address decode mode on.
// R10: Control bit 0 enables the first watchdog; control resets to 01h.
// R11: Sixteen-bit base address register, resets to zero.
// R12: Group-zero select bits route LED, watchdog or suspend outputs to pins.
// R13: Control and base address registers reset by the bus reset.
// R14: Group registers reset only by their own group master reset.
// R15: Pins synchronised before edge detection; an edge beats a clearing read.
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps

module gpio_group_six_seven_port (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic group0_master_reset_i,
    input wire logic group6_master_reset_i,
    input wire logic group7_master_reset_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] group6_pin_i,
    output logic [7:0] group6_pin_o,
    output logic [7:0] group6_pin_oe_o,
    input wire logic group7_pin1_i,
    output logic group7_pin1_o,
    output logic group7_pin1_oe_o,
    input wire logic [7:0] group0_gpio_out_i,
    input wire logic [7:0] group0_gpio_oe_i,
    input wire logic yellow_led_out_i,
    input wire logic green_led_out_i,
    input wire logic watchdog_timeout_out_i,
    input wire logic suspend_led_out_i,
    output logic [7:0] group0_pin_o,
    output logic [7:0] group0_pin_oe_o,
    output logic first_watchdog_enable_o,
    output logic base_decode_active_o,
    output logic [15:0] io_base_address_o,
    output logic irq_o
);

    typedef struct packed {
        logic [7:0] dev_ctrl;
        logic [15:0] base_addr;
        logic [7:0] g0_func;
        logic [7:0] g6_dir;
        logic [7:0] g6_data;
        logic [7:0] g6_inv;
        logic [7:0] g6_stat;
        logic [7:0] g7_dir;
        logic [7:0] g7_data;
        logic [7:0] g7_inv;
        logic [7:0] g7_stat;
        logic [7:0] g6_s1;
        logic [7:0] g6_s2;
        logic [7:0] g6_s3;
        logic g7_s1;
        logic g7_s2;
        logic g7_s3;
        logic [8:0] irq_stat;
        logic [8:0] irq_mask;
        logic ack;
        logic [31:0] rdata;
    } state_type;

    state_type state;
    state_type next_state;

    logic bus_req;
    logic wr_commit;
    logic rd_commit;

    logic [7:0] g6_edge;
    logic [7:0] g7_edge;
    logic [8:0] events;
    logic [7:0] g7_pin_sync;
    logic [7:0] g7_pin_vec;

    // Register select on the word index of the byte address
    function automatic logic hit(input logic [11:0] adr, input logic [9:0] idx);
        hit = (adr[11:2] == idx);
    endfunction : hit

    // Merge write data into bits that are not inputs; input bits keep their value
    function automatic logic [7:0] merge_out(input logic [7:0] old, input logic [7:0] wd,
                                             input logic [7:0] dir);
        merge_out = (old & dir) | (wd & ~dir);
    endfunction : merge_out

    // Data read: outputs show the stored value, inputs the synchronised pin
    function automatic logic [7:0] data_view(input logic [7:0] data, input logic [7:0] pin,
                                             input logic [7:0] inv, input logic [7:0] dir);
        data_view = (data & ~dir) | ((pin ^ inv) & dir);
    endfunction : data_view

    // Commit happens on the edge where the master samples ack
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign wr_commit = bus_req & state.ack & wb_we_i;
    assign rd_commit = bus_req & state.ack & ~wb_we_i;

    // Group-seven layout, declared before any use
    localparam logic [7:0] GROUP7_IMPL_MASK_L = gpio_six_seven_pkg::GROUP7_IMPL_MASK;
    localparam int GROUP7_PIN_BIT_L = gpio_six_seven_pkg::GROUP7_PIN_BIT;

    // Edges are seen only after two synchronising flops [R15]
    assign g6_edge = state.g6_s2 ^ state.g6_s3; // [R4] [R6]
    assign g7_pin_sync = {6'h00, state.g7_s2, 1'h0};
    assign g7_pin_vec = {6'h00, state.g7_s3, 1'h0};
    assign g7_edge = (g7_pin_sync ^ g7_pin_vec) & GROUP7_IMPL_MASK_L; // [R7]
    assign events = {g7_edge[GROUP7_PIN_BIT_L], g6_edge};

    // Next-state logic: bus slave, pin capture, status, then resets
    always_comb begin
        next_state = state;
        next_state.ack = bus_req & ~state.ack;

        next_state.g6_s1 = group6_pin_i;
        next_state.g6_s2 = state.g6_s1;
        next_state.g6_s3 = state.g6_s2;

        next_state.g7_s1 = group7_pin1_i;
        next_state.g7_s2 = state.g7_s1;
        next_state.g7_s3 = state.g7_s2;

        // Read data is captured when the request is first seen
        if (bus_req && !state.ack) begin
            next_state.rdata = 32'h0000_0000;
            case (wb_adr_i[11:2])
                gpio_six_seven_pkg::IDX_DEVICE_CONTROL: next_state.rdata[7:0] = state.dev_ctrl;
                gpio_six_seven_pkg::IDX_IO_BASE_ADDRESS: next_state.rdata[15:0] = state.base_addr;
                gpio_six_seven_pkg::IDX_GROUP0_FUNCTION: next_state.rdata[7:0] = state.g0_func;
                gpio_six_seven_pkg::IDX_GROUP6_DIRECTION: next_state.rdata[7:0] = state.g6_dir;
                gpio_six_seven_pkg::IDX_GROUP6_DATA: begin
                    next_state.rdata[7:0] = data_view(state.g6_data, state.g6_s2, state.g6_inv,
                                                      state.g6_dir); // [R1] [R2] [R3]
                end
                gpio_six_seven_pkg::IDX_GROUP6_INVERSION: next_state.rdata[7:0] = state.g6_inv;
                gpio_six_seven_pkg::IDX_GROUP6_STATUS: next_state.rdata[7:0] = state.g6_stat;
                gpio_six_seven_pkg::IDX_GROUP7_DIRECTION: next_state.rdata[7:0] = state.g7_dir;
                gpio_six_seven_pkg::IDX_GROUP7_DATA: begin
                    next_state.rdata[7:0] = data_view(state.g7_data, g7_pin_sync, state.g7_inv,
                                                      state.g7_dir) & GROUP7_IMPL_MASK_L; // [R7]
                end
                gpio_six_seven_pkg::IDX_GROUP7_INVERSION: next_state.rdata[7:0] = state.g7_inv;
                gpio_six_seven_pkg::IDX_GROUP7_STATUS: next_state.rdata[7:0] = state.g7_stat;
                gpio_six_seven_pkg::IDX_IRQ_STATUS: next_state.rdata[8:0] = state.irq_stat;
                gpio_six_seven_pkg::IDX_IRQ_MASK: next_state.rdata[8:0] = state.irq_mask;
                default: next_state.rdata = 32'h0000_0000; // Unmapped reads as zero
            endcase
        end

        // Only bits reported in the captured read data are cleared, so an edge
        // landing between capture and commit survives the read [R5] [R15]
        next_state.g6_stat = state.g6_stat | g6_edge; // [R4]
        next_state.g7_stat = state.g7_stat | g7_edge;
        next_state.irq_stat = state.irq_stat | events;

        if (rd_commit && hit(wb_adr_i, gpio_six_seven_pkg::IDX_GROUP6_STATUS)) begin
            next_state.g6_stat = (state.g6_stat & ~state.rdata[7:0]) | g6_edge; // [R5]
        end

        if (rd_commit && hit(wb_adr_i, gpio_six_seven_pkg::IDX_GROUP7_STATUS)) begin
            next_state.g7_stat = (state.g7_stat & ~state.rdata[7:0]) | g7_edge; // [R5]
        end

        if (rd_commit && hit(wb_adr_i, gpio_six_seven_pkg::IDX_IRQ_STATUS)) begin
            next_state.irq_stat = (state.irq_stat & ~state.rdata[8:0]) | events;
        end

        // Register writes; byte lane 0 carries every 8-bit register
        if (wr_commit && wb_sel_i[0]) begin
            case (wb_adr_i[11:2])
                gpio_six_seven_pkg::IDX_DEVICE_CONTROL: begin
                    next_state.dev_ctrl = wb_dat_i[7:0] & gpio_six_seven_pkg::DEVICE_CONTROL_MASK; // [R9] [R10]
                end
                gpio_six_seven_pkg::IDX_IO_BASE_ADDRESS: next_state.base_addr[7:0] = wb_dat_i[7:0]; // [R11]
                gpio_six_seven_pkg::IDX_GROUP0_FUNCTION: next_state.g0_func = wb_dat_i[7:0];
                gpio_six_seven_pkg::IDX_GROUP6_DIRECTION: next_state.g6_dir = wb_dat_i[7:0];
                gpio_six_seven_pkg::IDX_GROUP6_DATA: begin
                    next_state.g6_data = merge_out(state.g6_data, wb_dat_i[7:0], state.g6_dir); // [R1] [R2]
                end
                gpio_six_seven_pkg::IDX_GROUP6_INVERSION: next_state.g6_inv = wb_dat_i[7:0];
                gpio_six_seven_pkg::IDX_GROUP7_DIRECTION: begin
                    next_state.g7_dir = wb_dat_i[7:0] & GROUP7_IMPL_MASK_L; // [R7] [R8]
                end
                gpio_six_seven_pkg::IDX_GROUP7_DATA: begin
                    next_state.g7_data = merge_out(state.g7_data, wb_dat_i[7:0], state.g7_dir)
                                         & GROUP7_IMPL_MASK_L; // [R2] [R7]
                end
                gpio_six_seven_pkg::IDX_GROUP7_INVERSION: begin
                    next_state.g7_inv = wb_dat_i[7:0] & GROUP7_IMPL_MASK_L; // [R7]
                end
                gpio_six_seven_pkg::IDX_IRQ_MASK: next_state.irq_mask[7:0] = wb_dat_i[7:0];
                default: next_state.rdata = next_state.rdata; // Status and unmapped: write ignored
            endcase
        end

        // Upper byte lane
        if (wr_commit && wb_sel_i[1] && hit(wb_adr_i, gpio_six_seven_pkg::IDX_IO_BASE_ADDRESS)) begin
            next_state.base_addr[15:8] = wb_dat_i[15:8]; // [R11]
        end
        if (wr_commit && wb_sel_i[1] && hit(wb_adr_i, gpio_six_seven_pkg::IDX_IRQ_MASK)) begin
            next_state.irq_mask[8] = wb_dat_i[8];
        end

        // Each power domain clears only on its own reset [R13] [R14]
        if (rst_i) begin
            next_state.dev_ctrl = gpio_six_seven_pkg::RST_DEVICE_CONTROL; // [R10] [R13]
            next_state.base_addr = gpio_six_seven_pkg::RST_IO_BASE_ADDRESS; // [R11] [R13]
            next_state.irq_stat = gpio_six_seven_pkg::RST_IRQ;
            next_state.irq_mask = gpio_six_seven_pkg::RST_IRQ;
            next_state.ack = 1'b0;
            next_state.rdata = 32'h0000_0000;
        end

        // Standby domain: one master reset per group
        if (group0_master_reset_i) begin
            next_state.g0_func = gpio_six_seven_pkg::RST_BYTE_ZERO; // [R14]
        end

        if (group6_master_reset_i) begin
            next_state.g6_dir = gpio_six_seven_pkg::RST_GROUP6_DIRECTION; // [R14]
            next_state.g6_data = gpio_six_seven_pkg::RST_BYTE_ZERO;
            next_state.g6_inv = gpio_six_seven_pkg::RST_BYTE_ZERO;
            next_state.g6_stat = gpio_six_seven_pkg::RST_BYTE_ZERO;
            next_state.g6_s1 = gpio_six_seven_pkg::RST_BYTE_ZERO;
            next_state.g6_s2 = gpio_six_seven_pkg::RST_BYTE_ZERO;
            next_state.g6_s3 = gpio_six_seven_pkg::RST_BYTE_ZERO;
        end

        if (group7_master_reset_i) begin
            next_state.g7_dir = gpio_six_seven_pkg::RST_GROUP7_DIRECTION; // [R8] [R14]
            next_state.g7_data = gpio_six_seven_pkg::RST_BYTE_ZERO;
            next_state.g7_inv = gpio_six_seven_pkg::RST_BYTE_ZERO;
            next_state.g7_stat = gpio_six_seven_pkg::RST_BYTE_ZERO;
            next_state.g7_s1 = 1'b0;
            next_state.g7_s2 = 1'b0;
            next_state.g7_s3 = 1'b0;
        end
    end

    // Single state register
    always_ff @(posedge clk_i) begin
        state <= next_state;
    end

    // Bus answer and control outputs
    assign wb_ack_o = state.ack;
    assign wb_dat_o = state.rdata;

    assign first_watchdog_enable_o = state.dev_ctrl[gpio_six_seven_pkg::WATCHDOG_ENABLE_BIT]; // [R10]
    assign base_decode_active_o = state.dev_ctrl[gpio_six_seven_pkg::BASE_DECODE_BIT]; // [R9]
    assign io_base_address_o = state.base_addr; // [R11]
    assign irq_o = |(state.irq_stat & state.irq_mask);

    // Pin drive: direction 0 drives, data is inverted toward the pin when asked
    assign group6_pin_o = state.g6_data ^ state.g6_inv; // [R1] [R3]
    assign group6_pin_oe_o = ~state.g6_dir;
    assign group7_pin1_o = state.g7_data[GROUP7_PIN_BIT_L] ^ state.g7_inv[GROUP7_PIN_BIT_L]; // [R3]
    assign group7_pin1_oe_o = ~state.g7_dir[GROUP7_PIN_BIT_L]; // [R8]

    // Group-zero routing; an alternate function always drives its pin
    generate
        for (genvar i = 0; i < 8; i++) begin : g_group0
            localparam logic [1:0] KIND = 2'(i % 4);
            logic alt;
            always_comb begin
                case (KIND)
                    gpio_six_seven_pkg::ALT_YELLOW_LED: alt = yellow_led_out_i;
                    gpio_six_seven_pkg::ALT_GREEN_LED: alt = green_led_out_i;
                    gpio_six_seven_pkg::ALT_WATCHDOG: alt = watchdog_timeout_out_i;
                    default: alt = suspend_led_out_i;
                endcase
            end
            // Select bit 1 hands the pin to its alternate source
            assign group0_pin_o[i] = state.g0_func[i] ? alt : group0_gpio_out_i[i]; // [R12]
            assign group0_pin_oe_o[i] = state.g0_func[i] | group0_gpio_oe_i[i]; // [R12]
        end
    endgenerate

    // Checks on the block's own behaviour
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i || group6_master_reset_i || group7_master_reset_i);

    // Data registers and pins
    a_write_drives_pin: assert property (wr_commit && wb_sel_i[0] // [R1]
        && hit(wb_adr_i, gpio_six_seven_pkg::IDX_GROUP6_DATA)
        |=> ((group6_pin_o ^ state.g6_inv) & group6_pin_oe_o) == ($past(wb_dat_i[7:0]) & group6_pin_oe_o))
        else $error("Output pin does not follow written data");

    a_input_read_pin: assert property (wb_ack_o && !wb_we_i // [R2]
        && hit(wb_adr_i, gpio_six_seven_pkg::IDX_GROUP6_DATA) && $stable(state.g6_inv)
        |-> (wb_dat_o[7:0] & state.g6_dir) == ($past(state.g6_s2 ^ state.g6_inv) & state.g6_dir))
        else $error("Input bit read does not show pin level");

    a_input_write_ignored: assert property (wr_commit && wb_sel_i[0] // [R2]
        && hit(wb_adr_i, gpio_six_seven_pkg::IDX_GROUP6_DATA)
        |=> ((state.g6_data ^ $past(state.g6_data)) & state.g6_dir) == 8'h00)
        else $error("Write changed an input bit");

    // Event status
    a_edge_sets_status: assert property (g6_edge != 8'h00 // [R4]
        |=> (state.g6_stat & $past(g6_edge)) == $past(g6_edge))
        else $error("Pin edge did not set status");

    a_read_clears_status: assert property (rd_commit && g6_edge == 8'h00 // [R5]
        && hit(wb_adr_i, gpio_six_seven_pkg::IDX_GROUP6_STATUS) && $past(g6_edge) == 8'h00
        |=> state.g6_stat == 8'h00)
        else $error("Status read did not clear");

    a_set_beats_clear: assert property (rd_commit && g7_edge != 8'h00 // [R15]
        && hit(wb_adr_i, gpio_six_seven_pkg::IDX_GROUP7_STATUS)
        |=> state.g7_stat[1] ##1 !rd_commit || state.g7_stat[1])
        else $error("Edge lost to clearing read");

    // Group seven, and group-six reset values
    a_group7_reserved: assert property (((state.g7_dir | state.g7_data | state.g7_inv // [R7]
        | state.g7_stat) & ~GROUP7_IMPL_MASK_L) == 8'h00)
        else $error("Reserved group-seven bit set");

    a_group7_dir_reset: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
        group7_master_reset_i |=> state.g7_dir == gpio_six_seven_pkg::RST_GROUP7_DIRECTION
        && group7_pin1_oe_o == 1'b0)
        else $error("Group-seven direction reset wrong");

    a_group6_reset_values: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
        group6_master_reset_i |=> group6_pin_oe_o == 8'h00 && state.g6_stat == 8'h00)
        else $error("Group-six reset values wrong");

    // Control, base address, routing and bus
    a_base_mode_write: assert property (wr_commit && wb_sel_i[0] // [R9]
        && hit(wb_adr_i, gpio_six_seven_pkg::IDX_DEVICE_CONTROL)
        |=> base_decode_active_o == $past(wb_dat_i[1]) && first_watchdog_enable_o == $past(wb_dat_i[0]))
        else $error("Decode mode does not follow control write");

    a_base_write: assert property (wr_commit && wb_sel_i[1:0] == 2'h3 // [R11]
        && hit(wb_adr_i, gpio_six_seven_pkg::IDX_IO_BASE_ADDRESS)
        |=> io_base_address_o == $past(wb_dat_i[15:0]))
        else $error("Base address write lost");

    a_bus_reset_values: assert property (@(posedge clk_i) disable iff (1'b0) rst_i // [R13]
        |=> first_watchdog_enable_o && !base_decode_active_o && io_base_address_o == 16'h0000)
        else $error("Bus reset values wrong");

    a_group0_route: assert property (state.g0_func[5] // [R12]
        |-> group0_pin_o[5] == watchdog_timeout_out_i && group0_pin_oe_o[5])
        else $error("Watchdog output not routed");

    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Ack held longer than one cycle");

    // Main scenarios
    c_status_read: cover property (rd_commit && state.g6_stat != 8'h00);
    c_edge_during_read: cover property (rd_commit && g6_edge != 8'h00);
    c_group7_output: cover property (group7_pin1_oe_o && group7_pin1_o);
    c_irq_raised: cover property (irq_o);
    c_set_beats_clear: cover property (rd_commit && g7_edge != 8'h00);

endmodule : gpio_group_six_seven_port

// >>> rtl/gpio_six_seven_pkg.sv
package gpio_six_seven_pkg;

    // Register indexes; byte address on the bus is four times the index
    localparam logic [9:0] IDX_DEVICE_CONTROL = 10'h030;
    localparam logic [9:0] IDX_IO_BASE_ADDRESS = 10'h060;
    localparam logic [9:0] IDX_GROUP0_FUNCTION = 10'h0E0;
    localparam logic [9:0] IDX_GROUP6_DIRECTION = 10'h0F8;
    localparam logic [9:0] IDX_GROUP6_DATA = 10'h0F9;
    localparam logic [9:0] IDX_GROUP6_INVERSION = 10'h0FA;
    localparam logic [9:0] IDX_GROUP6_STATUS = 10'h0FB;
    localparam logic [9:0] IDX_GROUP7_DIRECTION = 10'h0FC;
    localparam logic [9:0] IDX_GROUP7_DATA = 10'h0FD;
    localparam logic [9:0] IDX_GROUP7_INVERSION = 10'h0FE;
    localparam logic [9:0] IDX_GROUP7_STATUS = 10'h0FF;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h100;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h101;

    // Reset values
    localparam logic [7:0] RST_DEVICE_CONTROL = 8'h01;
    localparam logic [15:0] RST_IO_BASE_ADDRESS = 16'h0000;
    localparam logic [7:0] RST_BYTE_ZERO = 8'h00;
    localparam logic [7:0] RST_GROUP6_DIRECTION = 8'hFF;
    localparam logic [7:0] RST_GROUP7_DIRECTION = 8'h02;
    localparam logic [8:0] RST_IRQ = 9'h000;

    // Field layout
    localparam logic [7:0] DEVICE_CONTROL_MASK = 8'h03;
    localparam int WATCHDOG_ENABLE_BIT = 0;
    localparam int BASE_DECODE_BIT = 1;
    localparam logic [7:0] GROUP7_IMPL_MASK = 8'h02;
    localparam int GROUP7_PIN_BIT = 1;
    localparam int IRQ_WIDTH = 9;
    localparam int IRQ_GROUP7_BIT = 8;

    // Alternate function of a group-zero pin, by pin index modulo four
    localparam logic [1:0] ALT_SUSPEND_LED = 2'h0;
    localparam logic [1:0] ALT_WATCHDOG = 2'h1;
    localparam logic [1:0] ALT_GREEN_LED = 2'h2;
    localparam logic [1:0] ALT_YELLOW_LED = 2'h3;

endpackage : gpio_six_seven_pkg

// >>> sim/board_pins.sv
`timescale 1ns/1ps

// Board side of the port pins; the board holds a level on every line the device leaves undriven
module board_pins (
    input wire logic [8:0] drive_oe_i,
    input wire logic [8:0] drive_val_i,
    input wire logic [8:0] board_level_i,
    output logic [8:0] pin_level_o
);
    // The device wins where it drives, so its own output is what its input stage sees
    assign pin_level_o = (drive_oe_i & drive_val_i) | (~drive_oe_i & board_level_i);
endmodule : board_pins

// >>> sim/tb_gpio_group_six_seven_port.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fails++; $display("MISMATCH %0t got %h want %h", $time, got, exp); end end

module tb_gpio_group_six_seven_port;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic group0_master_reset_i = 1'b1, group6_master_reset_i = 1'b1, group7_master_reset_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o, note;
    logic [7:0] group6_pin_i, group6_pin_o, group6_pin_oe_o, group0_pin_o, group0_pin_oe_o;
    logic [7:0] group0_gpio_out_i = 8'h00, group0_gpio_oe_i = 8'h00;
    logic group7_pin1_i, group7_pin1_o, group7_pin1_oe_o, first_watchdog_enable_o, base_decode_active_o, irq_o;
    logic [3:0] alt = 4'h0; // Yellow, green, watchdog, suspend
    logic [15:0] io_base_address_o;
    logic [8:0] board = 9'h000; // Low from the start so no edge hides in the reset
    logic [8:0] pin_level;
    logic [31:0] expq[$];
    logic [31:0] seed = 32'h0001_1B24;
    int fails = 0;
    int compares = 0;

    gpio_group_six_seven_port u_dut (.clk_i, .rst_i, .group0_master_reset_i, .group6_master_reset_i,
        .group7_master_reset_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .group6_pin_i, .group6_pin_o, .group6_pin_oe_o, .group7_pin1_i, .group7_pin1_o,
        .group7_pin1_oe_o, .group0_gpio_out_i, .group0_gpio_oe_i, .yellow_led_out_i(alt[3]),
        .green_led_out_i(alt[2]), .watchdog_timeout_out_i(alt[1]), .suspend_led_out_i(alt[0]),
        .group0_pin_o, .group0_pin_oe_o, .first_watchdog_enable_o, .base_decode_active_o,
        .io_base_address_o, .irq_o);

    board_pins u_board (.drive_oe_i({group7_pin1_oe_o, group6_pin_oe_o}),
        .drive_val_i({group7_pin1_o, group6_pin_o}), .board_level_i(board), .pin_level_o(pin_level));
    assign group6_pin_i = pin_level[7:0];
    assign group7_pin1_i = pin_level[8];

    always #2.5 clk_i = ~clk_i;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    // Pin i takes the alternate source of slot i mod 4 when selected
    function automatic logic [7:0] g0_exp(input logic [7:0] s, input logic [7:0] g, input logic [3:0] a);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = s[i] ? a[i % 4] : g[i];
        return r;
    endfunction : g0_exp

    // One classic cycle; the request stands until ack is sampled, then drops for at least a cycle
    task automatic bus(input logic [9:0] idx, input logic w, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= s;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : bus

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        bus(idx, 1'b1, d, 4'h3);
    endtask : wr

    task automatic rd(input logic [9:0] idx, input logic [31:0] e);
        expq.push_back(e);
        bus(idx, 1'b0, 32'h00000000, 4'hF);
    endtask : rd

    task automatic close_out();
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out

    // Scoreboard: each read answer is matched against the oldest note in the queue
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i) begin
            note = expq.pop_front();
            `CHK(wb_dat_o, note)
        end
    end

    // Watchdog: the sequence needs only a few hundred cycles
    initial begin
        #50000;
        fails++;
        close_out();
    end

    initial begin
        logic [7:0] dir, d, v;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        {group0_master_reset_i, group6_master_reset_i, group7_master_reset_i} <= 3'b000;
        repeat (4) @(posedge clk_i);
        // Reset values
        rd(gpio_six_seven_pkg::IDX_DEVICE_CONTROL, 32'h01);
        rd(gpio_six_seven_pkg::IDX_IO_BASE_ADDRESS, 32'h0);
        rd(gpio_six_seven_pkg::IDX_GROUP0_FUNCTION, 32'h0);
        rd(gpio_six_seven_pkg::IDX_GROUP7_DIRECTION, 32'h02);
        rd(gpio_six_seven_pkg::IDX_GROUP6_STATUS, 32'h0);
        `CHK({group7_pin1_oe_o, group6_pin_oe_o}, 9'h000)
        // Edges on three pins; the interrupt stays low until unmasked
        board <= 9'h181;
        repeat (6) @(posedge clk_i);
        `CHK(irq_o, 1'b0)
        wr(gpio_six_seven_pkg::IDX_IRQ_MASK, 32'h1FF);
        @(negedge clk_i);
        `CHK(irq_o, 1'b1)
        rd(gpio_six_seven_pkg::IDX_GROUP6_STATUS, 32'h81);
        rd(gpio_six_seven_pkg::IDX_GROUP6_STATUS, 32'h0);
        rd(gpio_six_seven_pkg::IDX_GROUP7_STATUS, 32'h02);
        rd(gpio_six_seven_pkg::IDX_IRQ_STATUS, 32'h181);
        rd(gpio_six_seven_pkg::IDX_IRQ_STATUS, 32'h0);
        @(negedge clk_i);
        `CHK(irq_o, 1'b0)
        // Group seven: reserved bits read zero, the output passes through inversion
        wr(gpio_six_seven_pkg::IDX_GROUP7_INVERSION, 32'hFF);
        rd(gpio_six_seven_pkg::IDX_GROUP7_INVERSION, 32'h02);
        wr(gpio_six_seven_pkg::IDX_GROUP7_DIRECTION, 32'h00);
        wr(gpio_six_seven_pkg::IDX_GROUP7_DATA, 32'hFF);
        rd(gpio_six_seven_pkg::IDX_GROUP7_DATA, 32'h02);
        @(negedge clk_i);
        `CHK({group7_pin1_oe_o, group7_pin1_o}, 2'b10)
        // Random mix of directions, data and inversion on group six
        repeat (4) begin
            @(posedge clk_i);
            seed = lfsr(seed);
            {v, d, dir} = seed[23:0];
            board[7:0] <= seed[31:24];
            wr(gpio_six_seven_pkg::IDX_GROUP6_INVERSION, {24'h0, v});
            wr(gpio_six_seven_pkg::IDX_GROUP6_DIRECTION, {24'h0, dir});
            wr(gpio_six_seven_pkg::IDX_GROUP6_DATA, {24'h0, d});
            rd(gpio_six_seven_pkg::IDX_GROUP6_DATA, {24'h0, (d & ~dir) | ((board[7:0] ^ v) & dir)});
            @(negedge clk_i);
            `CHK(group6_pin_oe_o, ~dir)
            `CHK(group6_pin_o & ~dir, (d ^ v) & ~dir)
        end
        // Control, base address and an unmapped place
        wr(gpio_six_seven_pkg::IDX_DEVICE_CONTROL, 32'hFE);
        rd(gpio_six_seven_pkg::IDX_DEVICE_CONTROL, 32'h02);
        wr(gpio_six_seven_pkg::IDX_IO_BASE_ADDRESS, 32'h0FF8);
        rd(gpio_six_seven_pkg::IDX_IO_BASE_ADDRESS, 32'h0FF8);
        @(negedge clk_i);
        `CHK({base_decode_active_o, first_watchdog_enable_o, io_base_address_o}, 18'h20FF8)
        rd(10'h200, 32'h0); // Unmapped reads zero
        // Group-zero function select with random sources
        repeat (3) begin
            @(posedge clk_i);
            seed = lfsr(seed);
            group0_gpio_out_i <= seed[7:0];
            group0_gpio_oe_i <= seed[15:8];
            alt <= seed[19:16];
            wr(gpio_six_seven_pkg::IDX_GROUP0_FUNCTION, {24'h0, seed[31:24]});
            @(negedge clk_i);
            `CHK(group0_pin_o, g0_exp(seed[31:24], seed[7:0], seed[19:16]))
            `CHK(group0_pin_oe_o, seed[31:24] | seed[15:8])
        end
        // Bus reset spares the standby registers; group resets spare the bus registers
        wr(gpio_six_seven_pkg::IDX_GROUP6_INVERSION, 32'h5A);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        rd(gpio_six_seven_pkg::IDX_GROUP6_INVERSION, 32'h5A);
        rd(gpio_six_seven_pkg::IDX_DEVICE_CONTROL, 32'h01);
        wr(gpio_six_seven_pkg::IDX_DEVICE_CONTROL, 32'h02);
        {group0_master_reset_i, group6_master_reset_i, group7_master_reset_i} <= 3'b111;
        @(posedge clk_i);
        {group0_master_reset_i, group6_master_reset_i, group7_master_reset_i} <= 3'b000;
        rd(gpio_six_seven_pkg::IDX_GROUP6_INVERSION, 32'h0);
        rd(gpio_six_seven_pkg::IDX_GROUP0_FUNCTION, 32'h0);
        rd(gpio_six_seven_pkg::IDX_GROUP7_DIRECTION, 32'h02);
        rd(gpio_six_seven_pkg::IDX_DEVICE_CONTROL, 32'h02);
        board[8] <= 1'b0;
        rd(gpio_six_seven_pkg::IDX_GROUP7_STATUS, 32'h02);
        rd(gpio_six_seven_pkg::IDX_GROUP7_STATUS, 32'h02);
        rd(gpio_six_seven_pkg::IDX_GROUP7_STATUS, 32'h0);
        repeat (3) @(posedge clk_i);
        close_out();
    end
endmodule : tb_gpio_group_six_seven_port
